// ---- rtl/hpcb_device.sv ----
`timescale 1ns/1ps
`include "hpcb_regs.svh"
module hpcb_device
    import hpcb_pkg::*;
(
    // Clock and reset
    input  wire logic  mclk,
    input  wire logic  arst_n,
    // Host register port
    hpcb_if.dev        link,
    // Clock and power outputs
    output hpcb_dev_e  dev_state,
    output logic       xcvr_reset,
    output logic       pll_enable,
    output logic       osc_enable,
    output logic       clk_feed_en,
    output logic [7:0] clk_select
);
    typedef struct packed {
        hpcb_dev_e   st;
        logic        ack;
        logic [15:0] rdata;
        logic        irq_n;
        logic [7:0]  stat;
        logic [7:0]  ien;
        logic [7:0]  crst;
        logic [7:0]  pm;
        logic [15:0] wait_val;
        logic [7:0]  key;
        logic [7:0]  csel;
        logic [15:0] area0;
        logic [7:0]  epa;
        logic [7:0]  epb;
        logic        pll;
        logic        osc;
        logic        feed;
    } hpcb_dev_s;

    hpcb_dev_s s;
    hpcb_dev_s next_s;
    logic      take;
    logic      wr;
    logic      act;
    logic      tmr_start;
    logic      tmr_done;

    // ==========================================================
    // Oscillation wait countdown
    hpcb_wait_timer u_timer (
        .mclk   (mclk),
        .arst_n (arst_n),
        .start  (tmr_start),
        .load   (s.wait_val),
        .busy   (),
        .done   (tmr_done)
    );

    // Legal selector codes; 48 MHz has no oscillator code
    function automatic logic csel_ok(input logic [7:0] c);
        csel_ok = (c == `HPCB_CS_12OSC) || (c == `HPCB_CS_24OSC) ||
                  (c == `HPCB_CS_12EXT) || (c == `HPCB_CS_24EXT) ||
                  (c == `HPCB_CS_48EXT);
    endfunction : csel_ok

    // ==========================================================
    // Register access, power state and interrupt
    always_comb
    begin
        next_s     = s;
        next_s.ack = 1'b0;
        take       = link.req && !s.ack;
        wr         = take && link.we;
        act        = (s.st == DS_ACTIVE);
        tmr_start  = 1'b0;
        if (take)
        begin
            next_s.ack   = 1'b1;
            next_s.rdata = 16'h0000;
            if (s.st == DS_CUT)
            begin
                // Only a read of power control lets the host in
                if (!link.we && link.addr == `HPCB_A_PM)
                    next_s.st = DS_SLEEP;
            end
            else
            begin
                unique case (link.addr)
                    `HPCB_A_STAT:
                    begin
                        next_s.rdata[7:0] = s.stat;
                        if (wr)
                            next_s.stat = s.stat & ~link.wdata[7:0];
                    end
                    `HPCB_A_IEN:
                    begin
                        next_s.rdata[7:0] = s.ien;
                        if (wr)
                            next_s.ien = link.wdata[7:0];
                    end
                    `HPCB_A_CRST:
                    begin
                        next_s.rdata[7:0] = s.crst;
                        if (wr)
                            next_s.crst = link.wdata[7:0];
                    end
                    `HPCB_A_PM:
                    begin
                        next_s.rdata[7:0] = s.pm;
                        if (wr)
                            next_s.pm = link.wdata[7:0];
                    end
                    `HPCB_A_WAIT:
                    begin
                        next_s.rdata = s.wait_val;
                        if (wr)
                            next_s.wait_val = link.wdata;
                    end
                    `HPCB_A_KEY:
                    begin
                        next_s.rdata[7:0] = s.key;
                        if (wr)
                            next_s.key = link.wdata[7:0];
                    end
                    `HPCB_A_CSEL:
                    begin
                        next_s.rdata[7:0] = s.csel;
                        // Locked or unknown codes leave the clock alone
                        if (wr && s.key == `HPCB_KEY_OPEN &&
                            csel_ok(link.wdata[7:0]))
                            next_s.csel = link.wdata[7:0];
                    end
                    `HPCB_A_AREA0:
                    begin
                        if (act)
                        begin
                            next_s.rdata = s.area0;
                            if (wr)
                                next_s.area0 = link.wdata &
                                               `HPCB_AREA0_MSK;
                        end
                    end
                    `HPCB_A_EPA:
                    begin
                        if (act)
                        begin
                            next_s.rdata[7:0] = s.epa;
                            if (wr)
                                next_s.epa = link.wdata[7:0] &
                                             `HPCB_EP_MSK;
                        end
                    end
                    `HPCB_A_EPB:
                    begin
                        if (act)
                        begin
                            next_s.rdata[7:0] = s.epb;
                            if (wr)
                                next_s.epb = link.wdata[7:0] &
                                             `HPCB_EP_MSK;
                        end
                    end
                    default:
                    begin
                        next_s.rdata = 16'h0000;
                    end
                endcase
            end
        end

        // PLL may run once the macro leaves reset
        next_s.pll = !s.crst[`HPCB_B_XRST];

        // Go-active waits for a running PLL before counting
        if (s.st == DS_SLEEP && s.pm[`HPCB_B_GO] &&
            !s.crst[`HPCB_B_XRST])
        begin
            tmr_start  = 1'b1;
            next_s.st  = DS_WAIT;
            next_s.osc = 1'b1;
        end

        // Feed starts after the count; set beats a same-cycle clear
        if (s.st == DS_WAIT && tmr_done)
        begin
            next_s.st                 = DS_ACTIVE;
            next_s.feed               = 1'b1;
            next_s.stat[`HPCB_B_READY] = 1'b1;
        end

        next_s.irq_n = ~|(next_s.stat & next_s.ien);
    end

    // ==========================================================
    // State register
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s       <= '0;
            s.st    <= DS_CUT;
            s.irq_n <= 1'b1;
            s.crst  <= `HPCB_RST_CRST;
            s.key   <= `HPCB_RST_KEY;
            s.csel  <= `HPCB_RST_CSEL;
        end
        else
            s <= next_s;
    end

    // Outputs straight from the state register
    assign link.ack       = s.ack;
    assign link.rdata     = s.rdata;
    assign link.irq_out_n = s.irq_n;
    assign dev_state      = s.st;
    assign xcvr_reset     = s.crst[`HPCB_B_XRST];
    assign pll_enable     = s.pll;
    assign osc_enable     = s.osc;
    assign clk_feed_en    = s.feed;
    assign clk_select     = s.csel;
endmodule : hpcb_device

// ---- rtl/hpcb_regs.svh ----
`ifndef HPCB_REGS_SVH
`define HPCB_REGS_SVH
// What this block does
// - At 48 MHz only external clock code accepted
// - Clock codes: 12 MHz 00/80, 24 MHz 01/81
// - Key other than 0x56 locks clock selector
// - Host locks selector by writing key 0x00
// - Clearing chip reset bit 7 frees macro, PLL
// - External clock: host loads wait 0x0010
// - External oscillator: host loads wait 0x2500
// - Go-active bit starts oscillator, then clock feed
// - Host writes 0x40 to power control
// - Clock feed up sets status bit 0
// - Status and enable drive interrupt pin low
// - Writing one clears clock-ready status
// - Synchronous registers usable only when Active
// - Area0 bits 15:13, 1:0 read zero
// - Endpoint enable bit 7 reads zero
// - Host-cut until power control read, then Sleep

// ==========================================================
// Device register offsets
`define HPCB_A_STAT   8'h00
`define HPCB_A_IEN    8'h08
`define HPCB_A_CRST   8'h11
`define HPCB_A_PM     8'h12
`define HPCB_A_WAIT   8'h14
`define HPCB_A_KEY    8'h71
`define HPCB_A_CSEL   8'h73
`define HPCB_A_AREA0  8'h80
`define HPCB_A_EPA    8'hC6
`define HPCB_A_EPB    8'hC7

// ==========================================================
// Device fields, codes and reset values
`define HPCB_B_READY  0
`define HPCB_B_GO     6
`define HPCB_B_XRST   7
`define HPCB_B_EXT    7
`define HPCB_KEY_OPEN 8'h56
`define HPCB_KEY_LOCK 8'h00
`define HPCB_CS_12OSC 8'h00
`define HPCB_CS_24OSC 8'h01
`define HPCB_CS_12EXT 8'h80
`define HPCB_CS_24EXT 8'h81
`define HPCB_CS_48EXT 8'h83
`define HPCB_AREA0_MSK 16'h1FFC
`define HPCB_EP_MSK   8'h7F
`define HPCB_RST_CRST 8'h80
`define HPCB_RST_KEY  8'h56
`define HPCB_RST_CSEL 8'h00
`define HPCB_CRST_RUN 8'h00
`define HPCB_PM_GO    8'h40
`define HPCB_STAT_CLR 8'h01
`define HPCB_WAIT_EXT 16'h0010
`define HPCB_WAIT_OSC 16'h2500
`define HPCB_TICK_CYC 8'h04

// ==========================================================
// Controller register offsets and fields
`define HPCB_P_CTRL   8'h00
`define HPCB_P_CFG    8'h04
`define HPCB_P_RAW    8'h08
`define HPCB_P_RES    8'h0C
`define HPCB_P_IST    8'h10
`define HPCB_P_IMSK   8'h14
`define HPCB_C_START  0
`define HPCB_C_RAW    1
`define HPCB_RAW_WE   8

// ==========================================================
// Bring-up sequence steps
`define HPCB_S_PMRD   4'h0
`define HPCB_S_OPEN   4'h1
`define HPCB_S_CSEL   4'h2
`define HPCB_S_LOCK   4'h3
`define HPCB_S_CRST   4'h4
`define HPCB_S_WAIT   4'h5
`define HPCB_S_GO     4'h6
`define HPCB_S_POLL   4'h7
`define HPCB_S_CLR    4'h8
`endif

// ---- rtl/hpcb_pkg.sv ----
package hpcb_pkg;
    // ==========================================================
    // States
    typedef enum logic [1:0] {DS_CUT, DS_SLEEP, DS_WAIT, DS_ACTIVE}
        hpcb_dev_e;
    typedef enum logic [1:0] {HS_IDLE, HS_ISSUE, HS_WAIT} hpcb_host_e;

    // ==========================================================
    // One link access of the bring-up engine
    typedef struct packed {
        logic        we;
        logic [7:0]  addr;
        logic [15:0] data;
    } hpcb_op_s;
endpackage : hpcb_pkg

// ---- rtl/hpcb_if.sv ----
`timescale 1ns/1ps
// ==========================================================
// Host register port between controller and device
interface hpcb_if;
    logic        req;
    logic        we;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        ack;
    logic [15:0] rdata;
    logic        irq_out_n;

    modport dev  (input req, we, addr, wdata,
                  output ack, rdata, irq_out_n);
    modport host (output req, we, addr, wdata,
                  input ack, rdata, irq_out_n);
endinterface : hpcb_if

// ---- rtl/hpcb_wait_timer.sv ----
`timescale 1ns/1ps
`include "hpcb_regs.svh"
module hpcb_wait_timer
    import hpcb_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // Control
    input  wire logic        start,
    input  wire logic [15:0] load,
    // Status
    output logic             busy,
    output logic             done
);
    typedef struct packed {
        logic        busy;
        logic        done;
        logic [7:0]  pre;
        logic [15:0] cnt;
    } hpcb_tmr_s;

    hpcb_tmr_s s;
    hpcb_tmr_s next_s;

    // ==========================================================
    // Prescaled countdown; a zero load still waits one tick
    always_comb
    begin
        next_s = s;
        next_s.done = 1'b0;
        if (start)
        begin
            next_s.busy = 1'b1;
            next_s.pre  = 8'h00;
            next_s.cnt  = load;
        end
        else if (s.busy)
        begin
            if (s.pre == `HPCB_TICK_CYC - 8'h01)
            begin
                next_s.pre = 8'h00;
                if (s.cnt == 16'h0000)
                begin
                    next_s.busy = 1'b0;
                    next_s.done = 1'b1;
                end
                else
                    next_s.cnt = s.cnt - 16'h0001;
            end
            else
                next_s.pre = s.pre + 8'h01;
        end
    end

    // State register
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            s <= '0;
        else
            s <= next_s;
    end

    assign busy = s.busy;
    assign done = s.done;
endmodule : hpcb_wait_timer

// ---- rtl/hpcb_host.sv ----
`timescale 1ns/1ps
`include "hpcb_regs.svh"
module hpcb_host
    import hpcb_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    // Interrupt
    output logic             irq,
    // Device register port
    hpcb_if.host             link
);
    typedef struct packed {
        hpcb_host_e  st;
        logic        raw;
        logic [3:0]  step;
        logic        req;
        hpcb_op_s    op;
        logic [15:0] res;
        logic [2:0]  ist;
        logic [2:0]  imsk;
        logic [7:0]  csel;
        logic [15:0] wait_val;
        logic [24:0] rawcmd;
        logic        irq_prev;
        logic        pready;
        logic [31:0] prdata;
        logic        irq;
    } hpcb_host_s;

    hpcb_host_s s;
    hpcb_host_s next_s;
    logic       wcommit;
    logic [2:0] ev;

    // ==========================================================
    // Bring-up step table
    function automatic hpcb_op_s op_of(input logic [3:0] step,
                                       input logic [7:0] sel,
                                       input logic [15:0] wv);
        op_of = '0;
        unique case (step)
            `HPCB_S_PMRD: op_of = '{1'b0, `HPCB_A_PM, 16'h0000};
            `HPCB_S_OPEN: op_of = '{1'b1, `HPCB_A_KEY,
                                    {8'h00, `HPCB_KEY_OPEN}};
            `HPCB_S_CSEL: op_of = '{1'b1, `HPCB_A_CSEL, {8'h00, sel}};
            `HPCB_S_LOCK: op_of = '{1'b1, `HPCB_A_KEY,
                                    {8'h00, `HPCB_KEY_LOCK}};
            `HPCB_S_CRST: op_of = '{1'b1, `HPCB_A_CRST,
                                    {8'h00, `HPCB_CRST_RUN}};
            `HPCB_S_WAIT:
            begin
                // Zero picks the default for the clock source
                op_of = '{1'b1, `HPCB_A_WAIT, wv};
                if (wv == 16'h0000)
                    op_of.data = sel[`HPCB_B_EXT] ? `HPCB_WAIT_EXT
                                                  : `HPCB_WAIT_OSC;
            end
            `HPCB_S_GO:   op_of = '{1'b1, `HPCB_A_PM,
                                    {8'h00, `HPCB_PM_GO}};
            `HPCB_S_POLL: op_of = '{1'b0, `HPCB_A_STAT, 16'h0000};
            `HPCB_S_CLR:  op_of = '{1'b1, `HPCB_A_STAT,
                                    {8'h00, `HPCB_STAT_CLR}};
            default:      op_of = '0;
        endcase
    endfunction : op_of

    // ==========================================================
    // APB registers and sequencing engine
    always_comb
    begin
        next_s        = s;
        ev            = 3'b000;
        next_s.pready = 1'b0;
        wcommit       = psel && penable && pwrite && s.pready;
        // Answer one cycle into the access phase
        if (psel && penable && !s.pready)
        begin
            next_s.pready = 1'b1;
            unique case (paddr)
                `HPCB_P_CFG:  next_s.prdata = {s.wait_val, 8'h00, s.csel};
                `HPCB_P_RAW:  next_s.prdata = {s.rawcmd[24:9], 7'h00,
                                               s.rawcmd[8:0]};
                `HPCB_P_RES:  next_s.prdata = {13'h0000, !link.irq_out_n,
                                               s.st != HS_IDLE, 1'b0,
                                               s.res};
                `HPCB_P_IST:  next_s.prdata = {29'h0, s.ist};
                `HPCB_P_IMSK: next_s.prdata = {29'h0, s.imsk};
                default:      next_s.prdata = 32'h0000_0000;
            endcase
        end
        if (wcommit)
        begin
            unique case (paddr)
                `HPCB_P_CTRL:
                begin
                    if (s.st == HS_IDLE && pwdata[`HPCB_C_START])
                    begin
                        next_s.st   = HS_ISSUE;
                        next_s.raw  = 1'b0;
                        next_s.step = `HPCB_S_PMRD;
                    end
                    else if (s.st == HS_IDLE && pwdata[`HPCB_C_RAW])
                    begin
                        next_s.st  = HS_ISSUE;
                        next_s.raw = 1'b1;
                    end
                end
                `HPCB_P_CFG:
                begin
                    next_s.csel     = pwdata[7:0];
                    next_s.wait_val = pwdata[31:16];
                end
                `HPCB_P_RAW:  next_s.rawcmd = {pwdata[31:16], pwdata[8:0]};
                `HPCB_P_IST:  next_s.ist = s.ist & ~pwdata[2:0];
                `HPCB_P_IMSK: next_s.imsk = pwdata[2:0];
                default:      next_s.ist = next_s.ist;
            endcase
        end

        // Link sequencing: request held until the device acks
        unique case (s.st)
            HS_IDLE:
                next_s.req = 1'b0;
            HS_ISSUE:
            begin
                next_s.req = 1'b1;
                next_s.st  = HS_WAIT;
                if (s.raw)
                    next_s.op = '{s.rawcmd[`HPCB_RAW_WE],
                                  s.rawcmd[7:0], s.rawcmd[24:9]};
                else
                    next_s.op = op_of(s.step, s.csel, s.wait_val);
            end
            HS_WAIT:
            begin
                if (link.ack)
                begin
                    next_s.req = 1'b0;
                    next_s.res = link.rdata;
                    next_s.st  = HS_ISSUE;
                    if (s.raw)
                    begin
                        next_s.st = HS_IDLE;
                        ev[1]     = 1'b1;
                    end
                    else if (s.step == `HPCB_S_CLR)
                    begin
                        next_s.st = HS_IDLE;
                        ev[0]     = 1'b1;
                    end
                    // Keep polling until the clock feed is reported
                    else if (s.step != `HPCB_S_POLL ||
                             link.rdata[`HPCB_B_READY])
                        next_s.step = s.step + 4'h1;
                end
            end
            default:
                next_s.st = HS_IDLE;
        endcase

        // Device interrupt pin falling edge
        next_s.irq_prev = !link.irq_out_n;
        ev[2]           = !link.irq_out_n && !s.irq_prev;
        // Events after the clear so that a set wins
        next_s.ist = next_s.ist | ev;
        next_s.irq = |(next_s.ist & next_s.imsk);
    end

    // ==========================================================
    // State register
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            s <= '0;
        else
            s <= next_s;
    end

    // Outputs straight from the state register
    assign pready     = s.pready;
    assign prdata     = s.prdata;
    assign irq        = s.irq;
    assign link.req   = s.req;
    assign link.we    = s.op.we;
    assign link.addr  = s.op.addr;
    assign link.wdata = s.op.data;
endmodule : hpcb_host

// ---- sim/hpcb_link_checker.sv ----
`timescale 1ns/1ps
// ==========================================================
// Link protocol watcher
module hpcb_link_checker (
    // Clock and reset
    input logic        mclk,
    input logic        arst_n,
    // Link signals
    input logic        req,
    input logic        we,
    input logic [7:0]  addr,
    input logic [15:0] wdata,
    input logic        ack,
    input logic [15:0] rdata,
    input logic        irq_out_n
);
    logic take;
    logic woke;

    // Access taken at this edge
    assign take = req && !ack;

    // Set once power control has been read out of the cut state
    always_ff @(posedge mclk or negedge arst_n)
        if (!arst_n)
            woke <= 1'b0;
        else if (take && !we && addr == 8'h12)
            woke <= 1'b1;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    // ==========================================================
    // Handshake
    a_ack_pulse: assert property (ack |=> !ack)
        else $error("ack held past one cycle");
    a_ack_answer: assert property (take |=> ack)
        else $error("taken access not answered");
    a_ack_cause: assert property (!req |=> !ack)
        else $error("ack without request");
    a_req_hold: assert property (take |=> req && $stable({we, addr, wdata}))
        else $error("request changed before ack");
    a_req_drop: assert property (ack |=> !req)
        else $error("request kept after ack");

    // ==========================================================
    // Register behaviour seen on the link
    a_cut_zero: assert property (
        take && !we && !woke && addr != 8'h12 |=> rdata == 16'h0000)
        else $error("cut state read not zero");
    a_area0_zero: assert property (
        ack && !we && addr == 8'h80 |-> (rdata & 16'hE003) == 16'h0000)
        else $error("area0 fixed bits not zero");
    a_ep_zero: assert property (
        ack && !we && (addr == 8'hC6 || addr == 8'hC7) |-> !rdata[7])
        else $error("endpoint enable bit7 not zero");
    a_ien_clear: assert property (
        take && we && addr == 8'h08 && !wdata[0] |-> ##[2:3] irq_out_n)
        else $error("pin low after enable cleared");
    a_stat_clear: assert property (
        take && we && addr == 8'h00 && wdata[0] |-> ##[2:3] irq_out_n)
        else $error("pin low after status cleared");

    c_cut_read: cover property (take && !we && !woke);
    c_irq_low: cover property (!irq_out_n);
    c_area0: cover property (ack && !we && addr == 8'h80);
endmodule : hpcb_link_checker

// ---- sim/host_port_clock_bringup_test.sv ----
`timescale 1ns/1ps
module host_port_clock_bringup_test
    import hpcb_pkg::*;
;
    logic        mclk = 1'b0, arst_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'h64CD;
    logic        pready, irq, xcvr_reset, pll_enable, osc_enable, clk_feed_en;
    logic [7:0]  clk_select;
    hpcb_dev_e   dev_state;
    logic [63:0] q[$];
    logic [63:0] note;
    int          err_count = 0, checked = 0, cycles = 0;

    hpcb_if link_if ();
    hpcb_host u_hpcb_host (.mclk(mclk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .irq(irq), .link(link_if));
    hpcb_device u_hpcb_device (.mclk(mclk), .arst_n(arst_n), .link(link_if),
        .dev_state(dev_state), .xcvr_reset(xcvr_reset),
        .pll_enable(pll_enable), .osc_enable(osc_enable),
        .clk_feed_en(clk_feed_en), .clk_select(clk_select));
    hpcb_link_checker u_hpcb_link_checker (.mclk(mclk), .arst_n(arst_n),
        .req(link_if.req), .we(link_if.we), .addr(link_if.addr),
        .wdata(link_if.wdata), .ack(link_if.ack), .rdata(link_if.rdata),
        .irq_out_n(link_if.irq_out_n));

    always #5 mclk = ~mclk;

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done;
        $display("errors=%0d checks=%0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    // APB master; a read notes mask and expected value, mask 0 = no check
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, m, e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w)
            q.push_back({m, e});
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb

    // One link access through the controller; done flag polled, not busy,
    // since busy clears when the access ends while the done flag stays set
    task automatic raw(input logic w, input logic [7:0] a,
                       input logic [15:0] d, e);
        logic [31:0] m;
        m = (a == 8'h14 || a == 8'h80) ? 32'hFFFF : 32'hFF;
        apb(1'b1, 8'h08, {d, 7'h00, w, a}, 0, 0);
        apb(1'b1, 8'h00, 32'h2, 0, 0);
        rd = 0;
        while (!rd[1])
            apb(1'b0, 8'h10, 0, 0, 0);
        apb(1'b1, 8'h10, 32'h2, 0, 0);
        if (!w)
            apb(1'b0, 8'h0C, 0, m, {16'h0, e} & m);
    endtask : raw

    // Result watcher: oldest note against each read answer
    always @(posedge mclk)
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            note = q.pop_front();
            if (note[63:32] != 0)
                chk(prdata & note[63:32], note[31:0]);
        end

    // Hang guard above the ~40k cycles of the slow oscillator wait
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            err_count++;
            test_done();
        end
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        chk({dev_state, xcvr_reset, pll_enable}, {DS_CUT, 2'b10});
        raw(1'b1, 8'h14, 16'h1234, 0);
        raw(1'b0, 8'h14, 0, 16'h0000);
        raw(1'b0, 8'h12, 0, 16'h0000);
        chk(dev_state, DS_SLEEP);
        raw(1'b1, 8'h14, 16'hA5A5, 0);
        raw(1'b0, 8'h14, 0, 16'hA5A5);
        raw(1'b0, 8'h15, 0, 16'h0000);
        raw(1'b1, 8'h80, 16'hFFFF, 0);
        raw(1'b0, 8'h80, 0, 16'h0000);
        raw(1'b1, 8'h08, 16'h0001, 0);
        apb(1'b1, 8'h14, 32'h7, 0, 0);
        apb(1'b1, 8'h04, 32'h0010_0083, 0, 0);
        apb(1'b1, 8'h00, 32'h1, 0, 0);
        rd = 0;
        while (!rd[0])
            apb(1'b0, 8'h10, 0, 0, 0);
        apb(1'b0, 8'h10, 0, 32'h5, 32'h5);
        chk(irq, 1);
        chk({dev_state, osc_enable, clk_feed_en}, {DS_ACTIVE, 2'b11});
        chk({xcvr_reset, pll_enable, clk_select}, {2'b01, 8'h83});
        raw(1'b0, 8'h14, 0, 16'h0010);
        apb(1'b1, 8'h10, 32'h7, 0, 0);
        apb(1'b0, 8'h10, 0, 32'h7, 0);
        chk(irq, 0);
        raw(1'b0, 8'h00, 0, 16'h0000);
        chk(link_if.irq_out_n, 1);
        for (int i = 0; i < 4; i++)
        begin
            lfsr = next_rand(lfsr);
            raw(1'b1, 8'h80, lfsr[15:0], 0);
            raw(1'b0, 8'h80, 0, lfsr[15:0] & 16'h1FFC);
            raw(1'b1, 8'hC6 + {7'h0, i[0]}, lfsr[31:16], 0);
            raw(1'b0, 8'hC6 + {7'h0, i[0]}, 0, lfsr[23:16] & 8'h7F);
        end
        raw(1'b1, 8'h71, 16'h0056, 0);
        raw(1'b1, 8'h73, 16'h0003, 0);
        raw(1'b0, 8'h73, 0, 16'h0083);
        raw(1'b1, 8'h73, 16'h0081, 0);
        raw(1'b0, 8'h73, 0, 16'h0081);
        raw(1'b1, 8'h71, 16'h0011, 0);
        raw(1'b1, 8'h73, 16'h0080, 0);
        raw(1'b0, 8'h73, 0, 16'h0081);
        chk(clk_select, 8'h81);
        raw(1'b1, 8'h08, 16'h0000, 0);
        apb(1'b0, 8'h18, 0, 32'hFFFF_FFFF, 0);
        // Mid-run reset, then bring-up on the oscillator default wait
        arst_n <= 1'b0;
        @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        chk({dev_state, clk_feed_en, irq}, {DS_CUT, 2'b00});
        apb(1'b1, 8'h04, 32'h0000_0001, 0, 0);
        apb(1'b1, 8'h00, 32'h1, 0, 0);
        rd = 0;
        while (!rd[0])
            apb(1'b0, 8'h10, 0, 0, 0);
        raw(1'b0, 8'h14, 0, 16'h2500);
        chk({dev_state, clk_select}, {DS_ACTIVE, 8'h01});
        test_done();
    end
endmodule : host_port_clock_bringup_test
